// *** rtl/core_exec.sv ***
// Execution core: fetch, register file, multiplier, divider, exceptions
`timescale 1ns/10ps
module core_exec #(
	parameter int PcWidth = core_exec_pkg::PC_WIDTH,
	parameter int NumIrqs = core_exec_pkg::NUM_IRQS
) (
	input wire logic ref_clk,
	input wire logic resetn,
	output logic [core_exec_pkg::PC_WIDTH-1:0] progAddr_reg,
	output logic progRead_reg,
	input wire logic [core_exec_pkg::INSN_WIDTH-1:0] progData,
	output logic [core_exec_pkg::DATA_WIDTH-1:0] dataAddr_reg,
	output logic dataRead_reg,
	output logic dataWrite_reg,
	output logic [core_exec_pkg::DATA_WIDTH-1:0] dataWdata_reg,
	input wire logic [core_exec_pkg::DATA_WIDTH-1:0] dataRdata,
	input wire logic [core_exec_pkg::NUM_TRAPS-1:0] trapReq,
	input wire logic [core_exec_pkg::NUM_IRQS-1:0] irqReq,
	input wire logic [3*core_exec_pkg::NUM_IRQS-1:0] irqPrio,
	output logic excAck_reg,
	output logic [core_exec_pkg::IRQ_IDX_W:0] excId_reg,
	output logic progWindowEnable_reg,
	output logic divBusy_reg,
	output logic repeatActive_reg
);
	import core_exec_pkg::*;

	// Instruction fields: [23:20] op, [19:16] wd, [15:12] ws, [11:8] wt,
	// [7:5] mode, [4:0] flags; literal/branch use [15:0]
	logic [PC_WIDTH-1:0] programCounter_reg;
	logic [INSN_WIDTH-1:0] prefetch_reg;
	logic prefetchValid_reg;
	logic [DATA_WIDTH-1:0] workReg [NUM_WREGS];
	logic [DATA_WIDTH-1:0] coreControlRegister_reg;
	logic [PAGE_WIDTH-1:0] programWindowPage_reg;
	logic [DATA_WIDTH-1:0] repeatCount_reg;
	logic [4:0] divCount_reg;
	logic [2*DATA_WIDTH:0] divRem_reg;
	logic [DATA_WIDTH-1:0] divisor_reg;
	logic [3:0] divDst_reg;
	logic [2:0] cpuPrio_reg;
	logic [1:0] stall_reg;
	state_e state_reg;

	opcode_e op;
	logic [3:0] wd, ws, wt;
	logic [2:0] amode;
	logic [4:0] flags;
	logic excPending;
	logic [IRQ_IDX_W:0] excSel;
	logic [2:0] excPrio;

	assign op = opcode_e'(prefetch_reg[23:20]);
	assign wd = prefetch_reg[19:16];
	assign ws = prefetch_reg[15:12];
	assign wt = prefetch_reg[11:8];
	assign amode = prefetch_reg[7:5];
	assign flags = prefetch_reg[4:0];

	// Effective address per addressing group, used only by the ALU read
	function automatic logic [DATA_WIDTH-1:0] eff_addr(input logic [2:0] m,
		input logic [DATA_WIDTH-1:0] base, input logic [DATA_WIDTH-1:0] ofs);
		case (m)
			AM_IND_PREINC: eff_addr = base + 16'h_0002;
			AM_IND_PREDEC: eff_addr = base - 16'h_0002;
			AM_IND_OFFSET: eff_addr = base + ofs;
			default: eff_addr = base;
		endcase
	endfunction

	// Signed/unsigned/mixed product on a 17x17 array
	function automatic logic [2*DATA_WIDTH-1:0] mul17(input logic [15:0] a,
		input logic [15:0] b, input logic sa, input logic sb, input logic byteMode);
		logic signed [16:0] ea, eb;
		logic signed [33:0] p;
		ea = byteMode ? $signed({9'h_000, a[7:0]}) : $signed({sa & a[15], a});
		eb = byteMode ? $signed({9'h_000, b[7:0]}) : $signed({sb & b[15], b});
		p = ea * eb;
		mul17 = p[31:0];
	endfunction

	// Highest pending exception: traps first, then interrupt priority
	always_comb
	begin
		excPending = 1'b0;
		excSel = '0;
		excPrio = 3'h_0;
		for (int i = NUM_TRAPS - 1; i >= 0; i--)
			if (trapReq[i])
			begin
				excPending = 1'b1;
				excSel = (IRQ_IDX_W+1)'(NumIrqs + i);
				excPrio = NUM_PRIO;
			end
		if (!excPending)
			for (int j = 0; j < NumIrqs; j++)
				if (irqReq[j] && irqPrio[3*j +: 3] != 3'h_0 &&
					irqPrio[3*j +: 3] > excPrio && irqPrio[3*j +: 3] > cpuPrio_reg)
				begin
					excPending = 1'b1;
					excSel = (IRQ_IDX_W+1)'(j);
					excPrio = irqPrio[3*j +: 3];
				end
	end

	logic takeExc;
	logic issue;
	logic [PC_WIDTH-1:0] excVector;
	logic [PC_WIDTH-1:0] brTarget;
	// Entry only from the run state, so stalls never lose their acknowledge
	assign takeExc = excPending && state_reg == ST_RUN && prefetchValid_reg;
	assign issue = prefetchValid_reg && state_reg == ST_RUN && !takeExc && divCount_reg == 5'h_0;
	assign excVector = (excSel >= (IRQ_IDX_W+1)'(NumIrqs))
		? VEC_TRAP_BASE + PC_STEP * PC_WIDTH'(excSel - (IRQ_IDX_W+1)'(NumIrqs))
		: VEC_IRQ_BASE + PC_STEP * PC_WIDTH'(excSel);
	assign brTarget = (programCounter_reg + {{7{prefetch_reg[15]}}, prefetch_reg[15:0]}) & PC_MASK;

	// Program fetch: one word ahead
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			programCounter_reg <= PC_RESET;
			prefetch_reg <= '0;
			prefetchValid_reg <= 1'b0;
			progRead_reg <= 1'b0;
			progAddr_reg <= PC_RESET;
		end
		else
		begin
			progRead_reg <= 1'b1;
			if (takeExc)
			begin
				programCounter_reg <= excVector;
				prefetchValid_reg <= 1'b0;
			end
			else if (issue && (op == OP_BRA || op == OP_CALL))
			begin
				programCounter_reg <= brTarget;
				prefetchValid_reg <= 1'b0;
			end
			else if (issue && op == OP_RET)
			begin
				programCounter_reg <= {7'h_00, workReg[ws]} & PC_MASK;
				prefetchValid_reg <= 1'b0;
			end
			else if (state_reg == ST_RUN && divCount_reg == 5'h_0 &&
				!(issue && (op == OP_MOVD || op == OP_TABLE)) &&
				repeatCount_reg == '0)
			begin
				prefetch_reg <= progData;
				prefetchValid_reg <= 1'b1;
				programCounter_reg <= (programCounter_reg + PC_STEP) & PC_MASK;
			end
			progAddr_reg <= programCounter_reg;
		end
	end

	// Stall sequencer for MOVD/TABLE stalls and exception entry
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			state_reg <= ST_RUN;
			stall_reg <= 2'h_0;
			excAck_reg <= 1'b0;
			excId_reg <= '0;
		end
		else
		begin
			excAck_reg <= 1'b0;
			case (state_reg)
				ST_RUN:
					if (takeExc)
					begin
						state_reg <= ST_EXC;
						excAck_reg <= 1'b1;
						excId_reg <= excSel;
					end
					else if (issue && (op == OP_MOVD || op == OP_TABLE))
					begin
						state_reg <= ST_STALL;
						stall_reg <= 2'h_1;
					end
				ST_STALL:
					if (stall_reg == 2'h_0)
						state_reg <= ST_RUN;
					else
						stall_reg <= stall_reg - 2'h_1;
				ST_EXC:
					state_reg <= ST_RUN;
				default:
					state_reg <= ST_RUN;
			endcase
		end
	end

	// Working registers, stack and data bus
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			for (int k = 0; k < NUM_WREGS; k++)
				workReg[k] <= '0;
			workReg[SP_INDEX] <= SP_RESET;
			dataRead_reg <= 1'b0;
			dataWrite_reg <= 1'b0;
			dataAddr_reg <= '0;
			dataWdata_reg <= '0;
			cpuPrio_reg <= 3'h_0;
		end
		else
		begin
			dataRead_reg <= 1'b0;
			dataWrite_reg <= 1'b0;
			if (takeExc)
			begin
				dataWrite_reg <= 1'b1;
				dataAddr_reg <= workReg[SP_INDEX];
				dataWdata_reg <= programCounter_reg[15:0];
				workReg[SP_INDEX] <= workReg[SP_INDEX] + 16'h_0002;
				cpuPrio_reg <= excPrio;
			end
			else if (issue)
				case (op)
					OP_ALU:
					begin
						workReg[wd] <= workReg[ws] + dataRdata;
						dataRead_reg <= 1'b1;
						dataAddr_reg <= eff_addr(amode, workReg[wt], {11'h_000, flags});
					end
					OP_LIT:
						workReg[wd] <= prefetch_reg[15:0];
					OP_MUL:
					begin
						{workReg[wd + 4'h_1], workReg[wd]} <=
							mul17(workReg[ws], workReg[wt], flags[0], flags[1], flags[2]);
					end
					OP_CALL:
					begin
						dataWrite_reg <= 1'b1;
						dataAddr_reg <= workReg[SP_INDEX];
						dataWdata_reg <= programCounter_reg[15:0];
						workReg[SP_INDEX] <= workReg[SP_INDEX] + 16'h_0002;
					end
					OP_RET:
						workReg[SP_INDEX] <= workReg[SP_INDEX] - 16'h_0002;
					OP_MOVD, OP_TABLE:
					begin
						dataWrite_reg <= 1'b1;
						dataAddr_reg <= workReg[wd];
						dataWdata_reg <= workReg[ws];
					end
					default:
						dataRead_reg <= 1'b0;
				endcase
			if (divCount_reg == 5'h_1)
			begin
				workReg[divDst_reg] <= divRem_reg[DATA_WIDTH-1:0];
				workReg[divDst_reg + 4'h_1] <= divRem_reg[2*DATA_WIDTH-1:DATA_WIDTH];
			end
		end
	end

	// Repeat counter: holds fetch, re-issues the held word each cycle
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			repeatCount_reg <= '0;
		else if (issue && op == OP_REPEAT)
			repeatCount_reg <= prefetch_reg[15:0];
		else if (issue && repeatCount_reg != '0)
			repeatCount_reg <= repeatCount_reg - 16'h_0001;
	end

	// Iterative non-restoring divider; one quotient bit per step
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			divCount_reg <= 5'h_0;
			divRem_reg <= '0;
			divisor_reg <= '0;
			divDst_reg <= 4'h_0;
		end
		else if (issue && op == OP_DIV)
		begin
			divCount_reg <= DIV_CYCLES;
			divRem_reg <= {1'b0, flags[0] ? workReg[ws + 4'h_1] : 16'h_0000, workReg[ws]};
			divisor_reg <= workReg[wt];
			divDst_reg <= wd;
		end
		// Keeps stepping through exception entry so the length stays fixed
		else if (divCount_reg != 5'h_0)
		begin
			divCount_reg <= divCount_reg - 5'h_1;
			if (divCount_reg <= DIV_STEPS + 5'h_1 && divCount_reg > 5'h_1)
				divRem_reg <= divRem_reg[2*DATA_WIDTH]
					? {divRem_reg[2*DATA_WIDTH-1:0], 1'b0} + {1'b0, divisor_reg, 16'h_0001}
					: {divRem_reg[2*DATA_WIDTH-1:0], 1'b0} - {1'b0, divisor_reg, 16'h_0000}
						+ 33'h_0_0000_0001;
		end
	end

	// Core control and window page; window bit drives progWindowEnable_reg
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			coreControlRegister_reg <= CORE_CTRL_RESET;
			programWindowPage_reg <= PAGE_RESET[PAGE_WIDTH-1:0];
			progWindowEnable_reg <= 1'b0;
			divBusy_reg <= 1'b0;
			repeatActive_reg <= 1'b0;
		end
		else
		begin
			if (issue && op == OP_SETCTL)
			begin
				coreControlRegister_reg[CORE_CONTROL_REGISTER_WIN_BIT] <= prefetch_reg[CORE_CONTROL_REGISTER_WIN_BIT];
				programWindowPage_reg <= prefetch_reg[15:8];
			end
			progWindowEnable_reg <= coreControlRegister_reg[CORE_CONTROL_REGISTER_WIN_BIT];
			divBusy_reg <= divCount_reg != 5'h_0;
			repeatActive_reg <= repeatCount_reg != '0;
		end
	end

	logic unusedWindow;
	assign unusedWindow = ^{programWindowPage_reg, dataAddr_reg[WIN_BIT]};
endmodule // core_exec

// *** rtl/core_exec_pkg.sv ***
// Constants and types for the execution core
package core_exec_pkg;
	localparam int PC_WIDTH = 23;
	localparam int INSN_WIDTH = 24;
	localparam int DATA_WIDTH = 16;
	localparam int NUM_WREGS = 16;
	localparam int WREG_IDX_W = 4;
	localparam logic [3:0] SP_INDEX = 4'h_F;
	localparam logic [15:0] SP_RESET = 16'h_0800;
	localparam int PAGE_WIDTH = 8;
	localparam int WIN_BIT = 15;
	localparam int WIN_OFS_W = 15;
	localparam int CORE_CONTROL_REGISTER_WIN_BIT = 2;
	localparam logic [4:0] DIV_CYCLES = 5'h_13;
	localparam logic [4:0] DIV_STEPS = 5'h_10;
	localparam int NUM_TRAPS = 8;
	localparam int NUM_IRQS = 118;
	localparam int IRQ_IDX_W = 7;
	localparam logic [2:0] NUM_PRIO = 3'h_7;
	localparam logic [22:0] PC_RESET = 23'h_00_0000;
	localparam logic [22:0] PC_STEP = 23'h_00_0002;
	localparam logic [22:0] VEC_TRAP_BASE = 23'h_00_0004;
	localparam logic [22:0] VEC_IRQ_BASE = 23'h_00_0014;
	localparam logic [22:0] PC_MASK = 23'h_7F_FFFF;
	localparam logic [15:0] CORE_CTRL_RESET = 16'h_0000;
	localparam logic [15:0] PAGE_RESET = 16'h_0000;

	typedef enum logic [3:0] {
		OP_NOP = 4'h_0, OP_ALU = 4'h_1, OP_MUL = 4'h_2, OP_DIV = 4'h_3,
		OP_BRA = 4'h_4, OP_CALL = 4'h_5, OP_RET = 4'h_6, OP_REPEAT = 4'h_7,
		OP_MOVD = 4'h_8, OP_TABLE = 4'h_9, OP_LIT = 4'h_A, OP_SETCTL = 4'h_B
	} opcode_e;

	// Addressing mode groups share register-direct and indirect forms
	typedef enum logic [2:0] {
		AM_DIRECT = 3'h_0, AM_IND = 3'h_1, AM_IND_POSTINC = 3'h_2,
		AM_IND_POSTDEC = 3'h_3, AM_IND_PREINC = 3'h_4, AM_IND_PREDEC = 3'h_5,
		AM_IND_OFFSET = 3'h_6
	} amode_e;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00, ST_STALL = 2'b01, ST_EXC = 2'b11
	} state_e;
endpackage

// *** dv/core_exec_mem.sv ***
// Program and data memory model facing the core
`timescale 1ns/10ps
module core_exec_mem (
	input wire logic ref_clk,
	input wire logic [core_exec_pkg::PC_WIDTH-1:0] progAddr_reg,
	input wire logic progRead_reg,
	output logic [core_exec_pkg::INSN_WIDTH-1:0] progData,
	input wire logic [core_exec_pkg::DATA_WIDTH-1:0] dataAddr_reg,
	input wire logic dataRead_reg,
	input wire logic dataWrite_reg,
	input wire logic [core_exec_pkg::DATA_WIDTH-1:0] dataWdata_reg,
	output logic [core_exec_pkg::DATA_WIDTH-1:0] dataRdata
);
	import core_exec_pkg::*;
	logic [INSN_WIDTH-1:0] prog [256];
	logic [DATA_WIDTH-1:0] data [256];
	initial
	begin
		progData = '0;
		dataRdata = '0;
		foreach (prog[i]) prog[i] = '0;
		foreach (data[i]) data[i] = 16'h_A5A5;
	end
	// Idle cycles toggle the buses so stale words never look valid
	always @(posedge ref_clk)
	begin
		progData <= progRead_reg ? prog[progAddr_reg[8:1]] : ~progData;
		dataRdata <= dataRead_reg ? data[dataAddr_reg[8:1]] : ~dataRdata;
		if (dataWrite_reg)
			data[dataAddr_reg[8:1]] <= dataWdata_reg;
	end
endmodule // core_exec_mem

// *** dv/core_exec_chk.sv ***
// Port assertions for the execution core
`timescale 1ns/10ps
module core_exec_chk #(
	parameter int PcWidth = core_exec_pkg::PC_WIDTH,
	parameter int NumIrqs = core_exec_pkg::NUM_IRQS
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [core_exec_pkg::PC_WIDTH-1:0] progAddr_reg,
	input wire logic progRead_reg,
	input wire logic dataWrite_reg,
	input wire logic [core_exec_pkg::NUM_TRAPS-1:0] trapReq,
	input wire logic [core_exec_pkg::NUM_IRQS-1:0] irqReq,
	input wire logic [3*core_exec_pkg::NUM_IRQS-1:0] irqPrio,
	input wire logic excAck_reg,
	input wire logic [core_exec_pkg::IRQ_IDX_W:0] excId_reg,
	input wire logic progWindowEnable_reg,
	input wire logic divBusy_reg
);
	import core_exec_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Busy run length; a stuck divider shows up as an overlong run
	logic [4:0] divRun_reg;
	always_ff @(posedge ref_clk)
		divRun_reg <= (!resetn || !divBusy_reg) ? 5'h_00 : divRun_reg + 5'h_01;
	fetch_runs_a: assert property (resetn && $past(resetn) |-> progRead_reg)
		else $error("fetch strobe dropped");
	word_align_a: assert property (progRead_reg |-> !progAddr_reg[0])
		else $error("odd fetch address");
	ack_pulse_a: assert property (excAck_reg |=> !excAck_reg)
		else $error("ack longer than a cycle");
	ack_range_a: assert property (excAck_reg |-> excId_reg < NUM_IRQS + NUM_TRAPS)
		else $error("exception id out of range");
	ack_cause_a: assert property ($rose(excAck_reg) |-> $past(|trapReq) || $past(|irqReq))
		else $error("ack without request");
	prio_off_a: assert property (excAck_reg && excId_reg < NUM_IRQS
		|-> irqPrio[3*excId_reg +: 3] != 3'h_0)
		else $error("disabled source taken");
	div_length_a: assert property ($fell(divBusy_reg) |-> divRun_reg == DIV_CYCLES)
		else $error("divide length wrong");
	div_bound_a: assert property (divBusy_reg |-> divRun_reg < DIV_CYCLES)
		else $error("divide overran");
	stack_push_a: assert property ($rose(excAck_reg) |-> ##[0:4] dataWrite_reg)
		else $error("no state push on entry");
	cover property ($fell(divBusy_reg));
	cover property (excAck_reg && divBusy_reg);
	cover property ($rose(progWindowEnable_reg));
endmodule // core_exec_chk
bind core_exec core_exec_chk #(.PcWidth(PcWidth), .NumIrqs(NumIrqs)) core_exec_chk_i (
	.ref_clk(ref_clk), .resetn(resetn), .progAddr_reg(progAddr_reg),
	.progRead_reg(progRead_reg), .dataWrite_reg(dataWrite_reg), .trapReq(trapReq),
	.irqReq(irqReq), .irqPrio(irqPrio), .excAck_reg(excAck_reg), .excId_reg(excId_reg),
	.progWindowEnable_reg(progWindowEnable_reg), .divBusy_reg(divBusy_reg));

// *** dv/core_exec_bench.sv ***
// Self-checking bench for the execution core
`timescale 1ns/10ps
module core_exec_bench;
	import core_exec_pkg::*;
	logic ref_clk, resetn, progRead_reg, dataRead_reg, dataWrite_reg, pushSeen;
	logic excAck_reg, progWindowEnable_reg, divBusy_reg, repeatActive_reg;
	logic [PC_WIDTH-1:0] progAddr_reg;
	logic [INSN_WIDTH-1:0] progData;
	logic [DATA_WIDTH-1:0] dataAddr_reg, dataWdata_reg, dataRdata, firstPush;
	logic [NUM_TRAPS-1:0] trapReq;
	logic [NUM_IRQS-1:0] irqReq;
	logic [3*NUM_IRQS-1:0] irqPrio;
	logic [IRQ_IDX_W:0] excId_reg;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	core_exec core_exec_i (.ref_clk(ref_clk), .resetn(resetn), .progAddr_reg(progAddr_reg),
		.progRead_reg(progRead_reg), .progData(progData), .dataAddr_reg(dataAddr_reg),
		.dataRead_reg(dataRead_reg), .dataWrite_reg(dataWrite_reg),
		.dataWdata_reg(dataWdata_reg), .dataRdata(dataRdata), .trapReq(trapReq),
		.irqReq(irqReq), .irqPrio(irqPrio), .excAck_reg(excAck_reg), .excId_reg(excId_reg),
		.progWindowEnable_reg(progWindowEnable_reg), .divBusy_reg(divBusy_reg),
		.repeatActive_reg(repeatActive_reg));
	core_exec_mem core_exec_mem_i (.ref_clk(ref_clk), .progAddr_reg(progAddr_reg),
		.progRead_reg(progRead_reg), .progData(progData), .dataAddr_reg(dataAddr_reg),
		.dataRead_reg(dataRead_reg), .dataWrite_reg(dataWrite_reg),
		.dataWdata_reg(dataWdata_reg), .dataRdata(dataRdata));
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// First push after each reset shows where the stack starts
	always @(posedge ref_clk)
		if (!resetn)
			pushSeen <= 1'b0;
		else if (dataWrite_reg && !pushSeen)
		begin
			pushSeen <= 1'b1;
			firstPush <= dataAddr_reg;
		end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			close_out();
		end
	end
	task automatic do_reset();
		@(posedge ref_clk);
		resetn <= 1'b0;
		trapReq <= '0;
		irqReq <= '0;
		irqPrio <= '0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("reset fetch", 0, progRead_reg);
		chk("reset ack", 0, excAck_reg);
		chk("reset window", 0, progWindowEnable_reg);
		@(posedge ref_clk);
		resetn <= 1'b1;
		repeat (6) @(negedge ref_clk);
	endtask
	task automatic wait_ack(output int n);
		n = 0;
		while (excAck_reg !== 1'b1 && n < 30)
		begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	task automatic place(input logic [23:0] w, output logic [7:0] at);
		at = progAddr_reg[8:1] + 8'h_04;
		core_exec_mem_i.prog[at] = w;
	endtask
	task automatic t_fetch();
		@(posedge ref_clk);
		resetn <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk("first fetch", PC_RESET, progAddr_reg);
		for (int i = 1; i < 5; i++)
		begin
			@(negedge ref_clk);
			chk("fetch step", PC_RESET + i * PC_STEP, progAddr_reg);
		end
		chk("fetch strobe", 1, progRead_reg);
	endtask
	task automatic set_window(input logic en);
		logic [7:0] at;
		int n;
		place({OP_SETCTL, 4'h_0, 8'h_5A, 5'h_00, en, 2'h_0}, at);
		n = 0;
		while (progWindowEnable_reg !== en && n < 12)
		begin
			@(negedge ref_clk);
			n++;
		end
		core_exec_mem_i.prog[at] = '0;
		chk("window enable", en, progWindowEnable_reg);
	endtask
	task automatic t_div(input logic intr);
		logic [7:0] at;
		int n;
		do_reset();
		place({OP_DIV, 20'h_0_0000}, at);
		n = 0;
		while (divBusy_reg !== 1'b1 && n < 12)
		begin
			@(negedge ref_clk);
			n++;
		end
		core_exec_mem_i.prog[at] = '0;
		if (intr)
		begin
			@(posedge ref_clk);
			irqPrio[21 +: 3] <= 3'h_4;
			@(posedge ref_clk);
			irqReq[7] <= 1'b1;
			wait_ack(n);
			chk("divide irq id", 7, excId_reg);
			chk("divide irq delay", 1, n < 8);
		end
		else
		begin
			n = 0;
			while (divBusy_reg === 1'b1 && n < 40)
			begin
				@(negedge ref_clk);
				n++;
			end
			chk("divide cycles", DIV_CYCLES, n);
		end
	endtask
	task automatic t_repeat();
		logic [7:0] at;
		int n;
		do_reset();
		place({OP_REPEAT, 4'h_0, 16'h_0004}, at);
		n = 0;
		while (repeatActive_reg !== 1'b1 && n < 12)
		begin
			@(negedge ref_clk);
			n++;
		end
		core_exec_mem_i.prog[at] = '0;
		chk("repeat start", 1, repeatActive_reg);
		n = 0;
		while (repeatActive_reg === 1'b1 && n < 20)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk("repeat length", 4, n);
	endtask
	task automatic t_irq();
		int n;
		do_reset();
		@(posedge ref_clk);
		irqReq[5] <= 1'b1;
		wait_ack(n);
		chk("masked irq", 30, n);
		@(posedge ref_clk);
		irqReq[5] <= 1'b0;
		irqPrio[27 +: 3] <= 3'h_2;
		irqPrio[120 +: 3] <= 3'h_6;
		irqReq[9] <= 1'b1;
		irqReq[40] <= 1'b1;
		wait_ack(n);
		chk("urgent irq first", 40, excId_reg);
	endtask
	task automatic t_traps();
		int n;
		for (int k = 0; k < NUM_TRAPS; k++)
		begin
			do_reset();
			@(posedge ref_clk);
			trapReq[k] <= 1'b1;
			wait_ack(n);
			chk("trap ack", 1, excAck_reg);
			chk("trap id", NUM_IRQS + k, excId_reg);
			@(posedge ref_clk);
			trapReq[k] <= 1'b0;
			repeat (6) @(negedge ref_clk);
			chk("stack push", SP_RESET, firstPush);
		end
	endtask
	initial
	begin
		resetn = 1'b0;
		trapReq = '0;
		irqReq = '0;
		irqPrio = '0;
		pushSeen = 1'b0;
		repeat (3) @(posedge ref_clk);
		t_fetch();
		set_window(1'b1);
		set_window(1'b0);
		t_div(1'b0);
		t_div(1'b1);
		t_repeat();
		t_irq();
		t_traps();
		close_out();
	end
endmodule // core_exec_bench
